// >>> verilog/tcrs_map.svh
// Constant map of the trunk clock reference selector
`ifndef TCRS_MAP_SVH
`define TCRS_MAP_SVH
// Register indices on the plain register port
`define REG_CTRL      4'h0
`define REG_STATUS    4'h1
`define REG_EVENTS    4'h2
`define REG_MASK      4'h3
`define REG_NOMINAL   4'h4
`define REG_SPEC_TOL  4'h5
`define REG_LOCK_TOL  4'h6
`define REG_COUNTS    4'h7
// Field widths
`define DATA_W        16
`define CFG_W         8
`define EV_W          5
// Event bit positions
`define EV_LOCK       0
`define EV_UNLOCK     1
`define EV_SWITCH     2
`define EV_HOLDOVER   3
`define EV_FREERUN    4
// Reset values
`define NOMINAL_RST   8'h20
`define SPEC_TOL_RST  8'h04
`define LOCK_TOL_RST  8'h01
// Timing
`define REF_CLK_KHZ   50000
`define SYSCLK_KHZ    10240
`define CHATTER_US    1000
`define FLASH_HALF_MS 500
`define WIN_LAST      8'hff
`define CNT_MAX       8'hff
`define TRIM_MAX      12'h07ff
`define TRIM_MIN      12'h0801
`define TRIM_ONE      12'h0001
`endif

// >>> verilog/tcrs_pkg.sv
// Types shared by the trunk clock reference selector
`default_nettype none
`include "tcrs_map.svh"
package tcrs_pkg;
  typedef enum logic [4:0] {
    ST_DISABLED = 5'b00001,
    ST_FREERUN  = 5'b00010,
    ST_TRACKING = 5'b00100,
    ST_LOCKED   = 5'b01000,
    ST_HOLDOVER = 5'b10000
  } unit_state_t;
  typedef enum logic [1:0] {
    CMD_FREERUN   = 2'h0,
    CMD_TRACK_PRI = 2'h1,
    CMD_TRACK_SEC = 2'h2
  } cmd_t;
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_bus_t;
  typedef struct packed {
    logic driveLineOne;
    logic unitEnable;
    logic auxGroup;
    cmd_t cmd;
  } ctrl_t;
  typedef struct packed {
    logic [7:0] nominal;
    logic [7:0] specTol;
  } mon_cfg_t;
  typedef struct packed {
    logic [7:0] count;
    logic       inSpec;
    logic       alive;
  } mon_res_t;
  typedef struct packed {
    logic [1:0]  alive;
    logic [1:0]  inSpec;
    logic        pathEn;
    logic        selRef;
    unit_state_t state;
  } status_t;
  // Distance between two edge counts
  function automatic logic [7:0] absDiff(input logic [7:0] a, input logic [7:0] b);
    return (a > b) ? (a - b) : (b - a);
  endfunction
endpackage
`default_nettype wire

// >>> verilog/ref_monitor.sv
// Edge counting quality monitor for one reference clock
`default_nettype none
`include "tcrs_map.svh"
module ref_monitor import tcrs_pkg::*; (
  // Clock and reset
  input  wire logic     ref_clk,
  input  wire logic     rst,
  // Reference and control
  input  wire logic     refLevel,
  input  wire logic     enable,
  input  wire logic     windowTick,
  input  wire mon_cfg_t cfg,
  // Result of the last window
  output var  mon_res_t res
);
  typedef struct packed {
    logic       prev;
    logic [7:0] cnt;
    mon_res_t   res;
  } mon_state_t;
  mon_state_t q;
  mon_state_t d;

  // Count rising edges per window and grade the count
  always_comb begin
    d = q;
    d.prev = refLevel;
    if (refLevel && !q.prev && (q.cnt != `CNT_MAX)) begin
      d.cnt = q.cnt + 8'h01;
    end
    if (windowTick) begin
      d.cnt = '0;
      d.res.count = q.cnt;
      d.res.alive = (q.cnt != '0);
      d.res.inSpec = (q.cnt != '0) && (absDiff(q.cnt, cfg.nominal) <= cfg.specTol);
    end
    if (!enable) begin
      d = '0;
    end
  end

  // State register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign res = q.res;
endmodule // ref_monitor
`default_nettype wire

// >>> verilog/trunk_clock_reference_selector.sv
// Trunk clock reference selector: monitoring, switchover, holdover, system clock
//
// Operation
// - Unit is in exactly one mode at a time: tracking a reference or free-running.
// - Tracking pulls frequency toward reference, declares lock when near, keeps trimming.
// - Drift while locked drops back to tracking with flashing green until relock.
// - Free-run ignores references; entered by command or when both references die.
// - Generate phase-locked 10.24 MHz system clock; accept at most two references.
// - Reference in use out of spec, other good: switch automatically.
// - Both references out of spec: enter holdover, keep monitoring both.
// - Track-to-primary tracks primary, falls to good secondary when primary fails.
// - Primary command: leave holdover on first recovery, return to primary when good.
// - Track-to-secondary tracks secondary, falls to good primary when secondary fails.
// - Secondary command: leave holdover on first recovery, return to secondary when good.
// - Timeout after each automatic switch suppresses back-and-forth chatter.
// - Reference pair is both auxiliary inputs or both trunk clocks, never mixed.
// - Reference path enabled only while enable switch open; closed means path off.
`default_nettype none
`include "tcrs_map.svh"
module trunk_clock_reference_selector import tcrs_pkg::*; #(
  parameter int CHATTER_CYCLES = `CHATTER_US * `REF_CLK_KHZ / 1000,
  parameter int FLASH_CYCLES   = `FLASH_HALF_MS * `REF_CLK_KHZ
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Reference clock pins
  input  wire logic [1:0] trunkRefClk,
  input  wire logic [1:0] auxRefClk,
  input  wire logic       timingUnitSwitchClosed,
  // Register port
  input  wire reg_bus_t   regBus,
  output logic [15:0]     regRdData,
  // Clock and indicator outputs
  output logic            systemClk,
  output logic            refPathEnable,
  output logic            backplaneReferenceLineOne,
  output logic            backplaneReferenceLineOneOe,
  output logic            ledRed,
  output logic            ledGreen,
  output logic            irq
);
  localparam logic [23:0] NCO_STEP =
    24'(64'(2 * `SYSCLK_KHZ) * 64'h0100_0000 / 64'(`REF_CLK_KHZ));
  localparam logic [15:0] CHATTER_LOAD = 16'(CHATTER_CYCLES);
  localparam logic [24:0] FLASH_LAST = 25'(FLASH_CYCLES - 1);

  typedef struct packed {
    logic [3:0]          refMeta;
    logic [3:0]          refSync;
    logic                swMeta;
    logic                swSync;
    ctrl_t               ctrl;
    logic                cmdNew;
    logic [7:0]          nominal;
    logic [7:0]          specTol;
    logic [7:0]          lockTol;
    logic [`EV_W-1:0]    events;
    logic [`EV_W-1:0]    mask;
    unit_state_t         state;
    logic                selRef;
    logic [15:0]         chatter;
    logic [7:0]          winCnt;
    logic                winTick;
    logic                evalTick;
    logic [24:0]         flashCnt;
    logic                flashOn;
    logic [23:0]         nco;
    logic [11:0]         trim;
    logic                sysClk;
    logic                pathEn;
    logic                lineOne;
    logic                lineOneOe;
    logic                ledRed;
    logic                ledGreen;
    logic                irq;
    logic [15:0]         rdData;
  } sel_state_t;
  sel_state_t q;
  sel_state_t d;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // Reference monitors
  logic [1:0]      inSpec;
  logic [1:0]      alive;
  logic [1:0][7:0] monCount;
  logic            unitOn;
  logic            trackCmd;
  logic            pref;
  logic            curOk;
  logic            othOk;
  logic            anyAlive;
  logic [7:0]      selCount;
  logic            drift;
  status_t         status;

  // One monitor per reference, pair taken from one group only
  for (genvar i = 0; i < 2; i++) begin : g_mon
    mon_res_t res;
    mon_cfg_t cfg;
    assign cfg = '{nominal: q.nominal, specTol: q.specTol};
    ref_monitor u_mon (
      .ref_clk    (ref_clk),
      .rst        (rst),
      .refLevel   (q.ctrl.auxGroup ? q.refSync[2 + i] : q.refSync[i]),
      .enable     (unitOn),
      .windowTick (q.winTick),
      .cfg        (cfg),
      .res        (res)
    );
    assign inSpec[i] = res.inSpec;
    assign alive[i] = res.alive;
    assign monCount[i] = res.count;
  end

  // Decisions shared by the state machine and checks
  assign unitOn = !q.swSync && q.ctrl.unitEnable;
  assign trackCmd = (q.ctrl.cmd == CMD_TRACK_PRI) || (q.ctrl.cmd == CMD_TRACK_SEC);
  assign pref = (q.ctrl.cmd == CMD_TRACK_SEC);
  assign curOk = inSpec[q.selRef];
  assign othOk = inSpec[!q.selRef];
  assign anyAlive = |alive;
  assign selCount = monCount[q.selRef];
  assign drift = absDiff(selCount, q.nominal) > q.lockTol;
  assign status = '{alive: alive, inSpec: inSpec, pathEn: q.pathEn,
                    selRef: q.selRef, state: q.state};

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  logic [`EV_W-1:0] evSet;
  logic             evClr;
  logic [24:0]      ncoSum;

  always_comb begin
    d = q;
    evSet = '0;
    evClr = 1'b0;
    ncoSum = '0;
    // Pin synchronisers
    d.refMeta = {auxRefClk, trunkRefClk};
    d.refSync = q.refMeta;
    d.swMeta = timingUnitSwitchClosed;
    d.swSync = q.swMeta;
    // Monitoring window divider
    d.winCnt = q.winCnt + 8'h01;
    d.winTick = (q.winCnt == `WIN_LAST);
    d.evalTick = q.winTick;
    d.cmdNew = 1'b0;
    // Register writes
    if (regBus.wr) begin
      case (regBus.addr)
        `REG_CTRL: begin
          d.ctrl = ctrl_t'(regBus.wdata[$bits(ctrl_t)-1:0]);
          d.cmdNew = 1'b1;
        end
        `REG_MASK:     d.mask = regBus.wdata[`EV_W-1:0];
        `REG_NOMINAL:  d.nominal = regBus.wdata[`CFG_W-1:0];
        `REG_SPEC_TOL: d.specTol = regBus.wdata[`CFG_W-1:0];
        `REG_LOCK_TOL: d.lockTol = regBus.wdata[`CFG_W-1:0];
        default: ;
      endcase
    end
    // Register reads, data one cycle later
    d.rdData = '0;
    if (regBus.rd) begin
      case (regBus.addr)
        `REG_CTRL:     d.rdData = 16'($unsigned(q.ctrl));
        `REG_STATUS:   d.rdData = 16'($unsigned(status));
        `REG_EVENTS: begin
          d.rdData = 16'(q.events);
          evClr = 1'b1;
        end
        `REG_MASK:     d.rdData = 16'(q.mask);
        `REG_NOMINAL:  d.rdData = 16'(q.nominal);
        `REG_SPEC_TOL: d.rdData = 16'(q.specTol);
        `REG_LOCK_TOL: d.rdData = 16'(q.lockTol);
        `REG_COUNTS:   d.rdData = {monCount[1], monCount[0]};
        default:       d.rdData = '0;
      endcase
    end
    // Chatter timeout runs down
    if (q.chatter != '0) begin
      d.chatter = q.chatter - 16'h0001;
    end
    // Mode state machine
    if (!unitOn) begin
      d.state = ST_DISABLED;
      d.trim = '0;
      d.chatter = '0;
    end else begin
      case (q.state)
        ST_DISABLED: begin
          d.selRef = pref;
          d.state = trackCmd ? ST_TRACKING : ST_FREERUN;
        end
        ST_FREERUN, ST_HOLDOVER: begin
          if (!trackCmd) begin
            d.state = ST_FREERUN;
          end else if (inSpec[pref]) begin
            d.selRef = pref;
            d.state = ST_TRACKING;
          end else if (inSpec[!pref]) begin
            d.selRef = !pref;
            d.state = ST_TRACKING;
          end else if (q.state == ST_FREERUN && anyAlive) begin
            d.state = ST_HOLDOVER;
            evSet[`EV_HOLDOVER] = 1'b1;
          end else if (q.state == ST_HOLDOVER && !anyAlive) begin
            d.state = ST_FREERUN;
            evSet[`EV_FREERUN] = 1'b1;
          end
          if (d.state == ST_FREERUN) begin
            d.trim = '0;
          end
        end
        ST_TRACKING, ST_LOCKED: begin
          if (!trackCmd) begin
            d.state = ST_FREERUN;
            d.trim = '0;
            evSet[`EV_FREERUN] = 1'b1;
          end else if (q.cmdNew && (q.selRef != pref)) begin
            d.selRef = pref;
            d.state = ST_TRACKING;
          end else if (!anyAlive) begin
            d.state = ST_FREERUN;
            d.trim = '0;
            evSet[`EV_FREERUN] = 1'b1;
          end else if (!curOk && !othOk) begin
            d.state = ST_HOLDOVER;
            evSet[`EV_HOLDOVER] = 1'b1;
          end else if (!curOk && q.chatter == '0) begin
            d.selRef = !q.selRef;
            d.state = ST_TRACKING;
            d.chatter = CHATTER_LOAD;
            evSet[`EV_SWITCH] = 1'b1;
          end else if ((q.selRef != pref) && inSpec[pref] && q.chatter == '0) begin
            d.selRef = pref;
            d.state = ST_TRACKING;
            d.chatter = CHATTER_LOAD;
            evSet[`EV_SWITCH] = 1'b1;
          end else if (q.evalTick) begin
            // Frequency steering toward the reference
            if (selCount > q.nominal && q.trim != `TRIM_MAX) begin
              d.trim = q.trim + `TRIM_ONE;
            end else if (selCount < q.nominal && q.trim != `TRIM_MIN) begin
              d.trim = q.trim - `TRIM_ONE;
            end
            if (q.state == ST_LOCKED && drift) begin
              d.state = ST_TRACKING;
              evSet[`EV_UNLOCK] = 1'b1;
            end else if (q.state == ST_TRACKING && !drift) begin
              d.state = ST_LOCKED;
              evSet[`EV_LOCK] = 1'b1;
            end
          end
        end
        default: d.state = ST_DISABLED;
      endcase
    end
    // Sticky events, a new event beats the read clear
    d.events = (evClr ? '0 : q.events) | evSet;
    d.irq = |(d.events & d.mask);
    // Numerically controlled system clock
    ncoSum = {1'b0, q.nco} + {1'b0, NCO_STEP + {{12{q.trim[11]}}, q.trim}};
    d.nco = ncoSum[23:0];
    if (d.state == ST_DISABLED) begin
      d.sysClk = 1'b0;
    end else if (ncoSum[24]) begin
      d.sysClk = !q.sysClk;
    end
    // Flash divider for the tracking indication
    if (q.flashCnt == FLASH_LAST) begin
      d.flashCnt = '0;
      d.flashOn = !q.flashOn;
    end else begin
      d.flashCnt = q.flashCnt + 25'h000_0001;
    end
    // Indicators and paths
    d.pathEn = (d.state != ST_DISABLED);
    d.ledRed = !q.swSync && !q.ctrl.unitEnable;
    d.ledGreen = (d.state == ST_TRACKING) ? q.flashOn : (d.state != ST_DISABLED);
    d.lineOneOe = q.ctrl.driveLineOne;
    d.lineOne = q.ctrl.driveLineOne && q.refSync[0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.state <= ST_DISABLED;
      q.ctrl.cmd <= CMD_FREERUN;
      q.nominal <= `NOMINAL_RST;
      q.specTol <= `SPEC_TOL_RST;
      q.lockTol <= `LOCK_TOL_RST;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from flip-flops
  assign regRdData = q.rdData;
  assign systemClk = q.sysClk;
  assign refPathEnable = q.pathEn;
  assign backplaneReferenceLineOne = q.lineOne;
  assign backplaneReferenceLineOneOe = q.lineOneOe;
  assign ledRed = q.ledRed;
  assign ledGreen = q.ledGreen;
  assign irq = q.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  one_mode_a: assert property ($onehot(q.state))
    else $error("unit state not one-hot");

  lock_entry_a: assert property (
    $rose(q.state == ST_LOCKED) |-> $past(q.state) == ST_TRACKING && $past(q.evalTick))
    else $error("lock entered without tracking");

  drift_unlock_a: assert property (
    unitOn && trackCmd && !q.cmdNew && q.state == ST_LOCKED && q.evalTick && drift
    && curOk |=> q.state == ST_TRACKING && ledGreen == $past(q.flashOn))
    else $error("drift did not drop lock");

  freerun_cmd_a: assert property (
    unitOn && !trackCmd |=> q.state == ST_FREERUN && q.trim == '0)
    else $error("free-run command ignored");

  auto_switch_a: assert property (
    unitOn && trackCmd && !q.cmdNew && anyAlive && !curOk && othOk && q.chatter == '0
    && (q.state == ST_TRACKING || q.state == ST_LOCKED)
    |=> q.selRef != $past(q.selRef) && q.chatter == CHATTER_LOAD)
    else $error("no switchover to good reference");

  holdover_entry_a: assert property (
    unitOn && trackCmd && !q.cmdNew && anyAlive && inSpec == 2'b00
    && (q.state == ST_TRACKING || q.state == ST_LOCKED) |=> q.state == ST_HOLDOVER)
    else $error("holdover not entered");

  holdover_exit_a: assert property (
    unitOn && trackCmd && q.state == ST_HOLDOVER && inSpec[pref]
    |=> q.state == ST_TRACKING && q.selRef == $past(pref))
    else $error("holdover exit missed preferred");

  chatter_hold_a: assert property (
    (q.state == ST_TRACKING || q.state == ST_LOCKED) && q.chatter != '0 && curOk
    && unitOn && trackCmd && !q.cmdNew |=> q.selRef == $past(q.selRef))
    else $error("switch inside chatter timeout");

  path_off_a: assert property (
    q.swSync |=> q.state == ST_DISABLED && !refPathEnable)
    else $error("path on with switch closed");
endmodule // trunk_clock_reference_selector
`default_nettype wire

// >>> test/ref_source_model.sv
// Behavioural reference clock source standing in for one trunk card
`default_nettype none
module ref_source_model #(
  parameter int PHASE_NS = 7
) (
  // Requested half period in ns, zero for a dead source
  input  wire logic [7:0] halfNs,
  // Recovered clock toward the selector
  output var  logic       clk
);
  timeunit 1ns;
  timeprecision 100ps;

  ////////////////////////////////////////
  // Toggle at the requested rate; a dead source holds low, as a lost line does
  initial begin
    clk = 1'b0;
    #(PHASE_NS);
    forever begin
      if (halfNs == 8'h00) begin
        clk = 1'b0;
        #10;
      end else begin
        #(halfNs);
        clk = ~clk;
      end
    end
  end
endmodule // ref_source_model
`default_nettype wire

// >>> test/test_trunk_clock_reference_selector.sv
// Register level testbench of the trunk clock reference selector
`default_nettype none
`include "tcrs_map.svh"
module test_trunk_clock_reference_selector import tcrs_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic        ref_clk = 1'b0;
  logic        rst;
  logic [3:0]  srcClk;
  logic [7:0]  halfNs [4];
  logic        swClosed;
  reg_bus_t    regBus;
  logic [15:0] regRdData;
  logic        systemClk;
  logic        refPathEnable;
  logic        lineOne;
  logic        lineOneOe;
  logic        ledRed;
  logic        ledGreen;
  logic        irq;
  int          err_total = 0;
  int          comparisons = 0;
  logic [3:0]  rstAddr [8] = '{`REG_CTRL, `REG_STATUS, `REG_EVENTS, `REG_MASK,
                               `REG_NOMINAL, `REG_SPEC_TOL, `REG_LOCK_TOL, 4'h8};
  logic [15:0] rstVal [8] = '{16'h0000, 16'h0001, 16'h0000, 16'h0000,
                              16'h0020, 16'h0004, 16'h0001, 16'h0000};

  ////////////////////////////////////////
  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;

  // Device and the four reference sources, trunk pair then auxiliary pair
  trunk_clock_reference_selector #(
    .CHATTER_CYCLES (2000),
    .FLASH_CYCLES   (8)
  ) i_trunk_clock_reference_selector (
    .ref_clk                     (ref_clk),
    .rst                         (rst),
    .trunkRefClk                 (srcClk[1:0]),
    .auxRefClk                   (srcClk[3:2]),
    .timingUnitSwitchClosed      (swClosed),
    .regBus                      (regBus),
    .regRdData                   (regRdData),
    .systemClk                   (systemClk),
    .refPathEnable               (refPathEnable),
    .backplaneReferenceLineOne   (lineOne),
    .backplaneReferenceLineOneOe (lineOneOe),
    .ledRed                      (ledRed),
    .ledGreen                    (ledGreen),
    .irq                         (irq)
  );
  for (genvar g = 0; g < 4; g++) begin : g_src
    ref_source_model #(.PHASE_NS(3 + 11 * g)) i_ref_source_model (
      .halfNs (halfNs[g]),
      .clk    (srcClk[g])
    );
  end

  ////////////////////////////////////////
  // Compare and count
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One-cycle write strobe
  task automatic regWr(input logic [3:0] a, input logic [15:0] d);
    regBus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    regBus.wr <= 1'b0;
    #1;
  endtask

  // One-cycle read strobe; data stands only in the following cycle
  task automatic regRd(input logic [3:0] a, output logic [15:0] d);
    regBus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    regBus.rd <= 1'b0;
    #1 d = regRdData;
  endtask

  // Poll status until the masked field matches, bounded
  task automatic waitStatus(input logic [15:0] msk, input logic [15:0] val);
    logic [15:0] v;
    int          n;
    n = 0;
    regRd(`REG_STATUS, v);
    while (((v & msk) !== val) && n < 3000) begin
      regRd(`REG_STATUS, v);
      n++;
    end
    check("status", v & msk, val);
    check("one state", 16'($countones(v[4:0])), 16'h0001);
  endtask

  // Report and end the run
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  // Main sequence
  initial begin
    logic [15:0] v;
    logic        prevClk;
    logic        prevLine;
    int          n;
    int          m;
    rst = 1'b1;
    regBus = '0;
    swClosed = 1'b0;
    halfNs = '{8'h50, 8'h50, 8'h50, 8'h50};
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    // Reset values, unmapped place and read-only status
    for (int i = 0; i < 8; i++) begin
      regRd(rstAddr[i], v);
      check("reset value", v, rstVal[i]);
    end
    regWr(`REG_STATUS, 16'hffff);
    regRd(`REG_STATUS, v);
    check("status read only", v, 16'h0001);
    check("red led", {15'h0000, ledRed}, 16'h0001);
    // Switch closed keeps the path off despite software
    swClosed <= 1'b1;
    repeat (4) @(posedge ref_clk);
    regWr(`REG_CTRL, 16'h0019);
    repeat (4) @(posedge ref_clk);
    check("path while closed", {15'h0000, refPathEnable}, 16'h0000);
    check("line one enable", {15'h0000, lineOneOe}, 16'h0001);
    check("sysclk idle", {15'h0000, systemClk}, 16'h0000);
    waitStatus(16'h001f, 16'(ST_DISABLED));
    // Open switch: track then lock on primary
    swClosed <= 1'b0;
    waitStatus(16'h003f, 16'h0008);
    check("path open", {15'h0000, refPathEnable}, 16'h0001);
    check("green steady", {15'h0000, ledGreen}, 16'h0001);
    // System clock and line one rates over 20 us, sampled off the edge
    n = 0;
    m = 0;
    prevClk = systemClk;
    prevLine = lineOne;
    repeat (1000) begin
      @(negedge ref_clk);
      if (systemClk === 1'b1 && prevClk === 1'b0) n++;
      if (lineOne === 1'b1 && prevLine === 1'b0) m++;
      prevClk = systemClk;
      prevLine = lineOne;
    end
    check("sysclk rate", 16'(n >= 200 && n <= 210), 16'h0001);
    check("line one rate", 16'(m >= 124 && m <= 126), 16'h0001);
    // Interrupt masked, unmasked, cleared by reading events
    check("irq masked", {15'h0000, irq}, 16'h0000);
    regWr(`REG_MASK, 16'h0001);
    repeat (2) @(posedge ref_clk);
    check("irq raised", {15'h0000, irq}, 16'h0001);
    regRd(`REG_EVENTS, v);
    check("lock event", v & 16'h0001, 16'h0001);
    repeat (2) @(posedge ref_clk);
    check("irq cleared", {15'h0000, irq}, 16'h0000);
    // Nominal moved past lock tolerance: unlock, flashing green, then relock
    regWr(`REG_NOMINAL, 16'h0022);
    waitStatus(16'h003f, 16'h0004);
    regRd(`REG_EVENTS, v);
    check("unlock event", v & 16'h0002, 16'h0002);
    n = 0;
    prevClk = ledGreen;
    repeat (40) begin
      @(negedge ref_clk);
      if (ledGreen !== prevClk) n++;
      prevClk = ledGreen;
    end
    check("green flashing", 16'(n >= 4), 16'h0001);
    regWr(`REG_NOMINAL, 16'h0020);
    waitStatus(16'h003f, 16'h0008);
    // Primary dies: automatic switch, then chatter holds the return
    halfNs[0] <= 8'h00;
    waitStatus(16'h0020, 16'h0020);
    halfNs[0] <= 8'h50;
    waitStatus(16'h003f, 16'h0028);
    regRd(`REG_STATUS, v);
    check("chatter hold", v & 16'h0020, 16'h0020);
    waitStatus(16'h003f, 16'h0008);
    // Both alive but off frequency: holdover, secondary recovers first
    halfNs[0] <= 8'h28;
    halfNs[1] <= 8'h28;
    waitStatus(16'h061f, 16'h0610);
    halfNs[1] <= 8'h50;
    waitStatus(16'h0030, 16'h0020);
    halfNs[0] <= 8'h50;
    waitStatus(16'h003f, 16'h0008);
    // Both lost: free-run, then recovery on primary
    halfNs[0] <= 8'h00;
    halfNs[1] <= 8'h00;
    waitStatus(16'h001f, 16'(ST_FREERUN));
    halfNs[0] <= 8'h50;
    halfNs[1] <= 8'h50;
    waitStatus(16'h003f, 16'h0008);
    // Track secondary, lose it, get it back
    regWr(`REG_CTRL, 16'h000a);
    waitStatus(16'h003f, 16'h0028);
    halfNs[1] <= 8'h00;
    waitStatus(16'h0030, 16'h0000);
    halfNs[1] <= 8'h50;
    waitStatus(16'h003f, 16'h0028);
    // Auxiliary pair only, trunk pair dead
    halfNs[0] <= 8'h00;
    halfNs[1] <= 8'h00;
    regWr(`REG_CTRL, 16'h000d);
    waitStatus(16'h07bf, 16'h0788);
    // Software free-run command ignores good references
    regWr(`REG_CTRL, 16'h000c);
    waitStatus(16'h001f, 16'(ST_FREERUN));
    conclude();
  end

  // Watchdog far beyond the expected run length
  initial begin
    repeat (90000) @(posedge ref_clk);
    err_total++;
    conclude();
  end
endmodule // test_trunk_clock_reference_selector
`default_nettype wire
